// ---- hdl/dca_pkg.sv ----
// Shared constants and types for the eight-channel request arbiter
package dca_pkg;
  // Sizes
  localparam int NCH  = 8;                      // Number of channels
  localparam int CHW  = 3;                      // Channel index width
  localparam int DW   = 16;                     // Register and address width
  localparam int RAW  = 6;                      // Register address width
  localparam int CNTW = 10;                     // Transfer count width

  // Register address layout: [5] global, [4:2] channel, [1:0] register
  localparam int AB_GLOBAL = 5;
  localparam int CH_MSB    = 4;
  localparam int CH_LSB    = 2;
  localparam int RG_MSB    = 1;
  localparam logic [1:0]     REG_CTRL    = 2'h0;
  localparam logic [1:0]     REG_ADDR    = 2'h1;
  localparam logic [1:0]     REG_CNT     = 2'h2;
  localparam logic [RAW-1:0] ADDR_STATUS = 6'h20;
  localparam logic [RAW-1:0] ADDR_STATE  = 6'h21;

  // Control register fields
  localparam int CTRL_EN_BIT    = 15;
  localparam int CTRL_DIR_BIT   = 14;            // 1: memory to peripheral
  localparam int CTRL_FORCE_BIT = 13;            // Write-only, reads as zero
  localparam int CNT_BUF_BIT    = 10;            // Active buffer in count reg
  localparam int STATE_BUSY_BIT = 15;

  // Reset and constant values
  localparam logic [DW-1:0]   DATA_ZERO = 16'h0000;
  localparam logic [CNTW-1:0] CNT_ZERO  = 10'h000;
  localparam logic [CNTW-1:0] CNT_ONE   = 10'h001;
  localparam logic [DW-1:0]   ADDR_STEP = 16'h0001;
  localparam logic [NCH-1:0]  VEC_ZERO  = 8'h00;
  localparam logic [NCH-1:0]  VEC_ONE   = 8'h01;
  localparam logic [CHW-1:0]  CH_ZERO   = 3'h0;

  // Arbiter states
  typedef enum logic [0:0] {
    DCA_IDLE = 1'b0,
    DCA_BUSY = 1'b1
  } dca_state_t;
endpackage

// ---- hdl/dca_ch_if.sv ----
// Signals between the arbiter top and one channel
`timescale 1ns/1ps
interface dca_ch_if;
  logic            wr_ctrl;                     // Control register write
  logic            wr_addr;                     // Memory address write
  logic            ovr_clr;                     // Clear overrun flag
  logic [15:0]     wdata;                       // Write data
  logic            periph_req;                  // Peripheral request pulse
  logic            grant;                       // Channel holds the bus
  logic            done;                        // Granted transfer completed
  logic            en;                          // Channel enabled
  logic            dir;                         // Transfer direction
  logic            pending;                     // Held request
  logic            overrun;                     // Sticky overrun flag
  logic            buf_sel;                     // Active buffer
  logic [9:0]      len;                         // Last count of a block
  logic [9:0]      cnt;                         // Transfers in this block
  logic [15:0]     addr;                        // Memory address
  modport chan (input wr_ctrl, wr_addr, ovr_clr, wdata, periph_req, grant, done,
                output en, dir, pending, overrun, buf_sel, len, cnt, addr);
  modport ctrl (output wr_ctrl, wr_addr, ovr_clr, wdata, periph_req, grant, done,
                input en, dir, pending, overrun, buf_sel, len, cnt, addr);
endinterface

// ---- hdl/dca_channel.sv ----
// One channel: request latch, overrun flag, address and count
`timescale 1ns/1ps
module dca_channel
  import dca_pkg::*;
(
  input wire logic mclk_i,                      // System clock
  input wire logic rst_b_i,                     // Synchronous reset, low
  dca_ch_if.chan   ch                           // Link to the arbiter
);
  logic            en_reg,   en_next;
  logic            dir_reg,  dir_next;
  logic            pend_reg, pend_next;
  logic            ovr_reg,  ovr_next;
  logic            buf_reg,  buf_next;
  logic [CNTW-1:0] len_reg,  len_next;
  logic [CNTW-1:0] cnt_reg,  cnt_next;
  logic [DW-1:0]   addr_reg, addr_next;
  logic            force_req;
  logic            req_evt;
  logic            en_rise;

  // Next state of the channel
  always_comb begin
    force_req = ch.wr_ctrl & ch.wdata[CTRL_FORCE_BIT] & ~ch.grant;
    req_evt   = ch.periph_req | force_req;
    en_rise   = ch.wr_ctrl & ch.wdata[CTRL_EN_BIT] & ~en_reg;
    en_next   = ch.wr_ctrl ? ch.wdata[CTRL_EN_BIT] : en_reg;
    dir_next  = ch.wr_ctrl ? ch.wdata[CTRL_DIR_BIT] : dir_reg;
    len_next  = ch.wr_ctrl ? ch.wdata[CNTW-1:0] : len_reg;
    // Disabled channels drop requests, so enable before the peripheral
    pend_next = en_next & ((pend_reg & ~ch.done) | req_evt);
    // Only peripheral-to-memory duplicates count as overrun; set beats clear
    ovr_next  = (ovr_reg & ~ch.ovr_clr)
              | (pend_reg & ~ch.done & ch.periph_req & ~dir_reg);
    cnt_next  = cnt_reg;
    buf_next  = buf_reg;
    addr_next = addr_reg;
    if (en_rise) begin
      cnt_next = CNT_ZERO;
      buf_next = 1'b0;
    end else if (ch.done) begin
      if (cnt_reg == len_reg) begin
        cnt_next = CNT_ZERO;
        buf_next = ~buf_reg;
      end else begin
        cnt_next = cnt_reg + CNT_ONE;
      end
    end
    // Software correction wins over the post-transfer step
    if (ch.wr_addr) begin
      addr_next = ch.wdata;
    end else if (ch.done) begin
      addr_next = addr_reg + ADDR_STEP;
    end
  end

  // State registers
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      en_reg   <= 1'b0;
      dir_reg  <= 1'b0;
      pend_reg <= 1'b0;
      ovr_reg  <= 1'b0;
      buf_reg  <= 1'b0;
      len_reg  <= CNT_ZERO;
      cnt_reg  <= CNT_ZERO;
      addr_reg <= DATA_ZERO;
    end else begin
      en_reg   <= en_next;
      dir_reg  <= dir_next;
      pend_reg <= pend_next;
      ovr_reg  <= ovr_next;
      buf_reg  <= buf_next;
      len_reg  <= len_next;
      cnt_reg  <= cnt_next;
      addr_reg <= addr_next;
    end
  end

  // Outputs to the arbiter
  assign ch.en      = en_reg;
  assign ch.dir     = dir_reg;
  assign ch.pending = pend_reg;
  assign ch.overrun = ovr_reg;
  assign ch.buf_sel = buf_reg;
  assign ch.len     = len_reg;
  assign ch.cnt     = cnt_reg;
  assign ch.addr    = addr_reg;

  // Checks on the channel state
  AST_HOLD_PENDING: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    pend_reg && !ch.done && !ch.wr_ctrl |=> pend_reg)
    else $error("held request dropped without completion");
  AST_CLEAR_ON_DONE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $fell(pend_reg) |-> $past(ch.done) || $past(ch.wr_ctrl))
    else $error("request cleared without completed transfer");
  AST_DUP_ONCE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    pend_reg && ch.periph_req && !ch.done && !ch.wr_ctrl |=> pend_reg && $stable(cnt_reg))
    else $error("duplicate request counted");
  AST_OVR_P2M: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(ovr_reg) |-> $past(!dir_reg) && $past(pend_reg) && $past(ch.periph_req))
    else $error("overrun flagged for wrong direction or cause");
  AST_FORCE_BUSY: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    ch.grant && ch.done && ch.wr_ctrl && !ch.periph_req |=> !pend_reg)
    else $error("force accepted during transfer");
  AST_RESTART: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    ch.wr_ctrl && ch.wdata[CTRL_EN_BIT] && !en_reg |=> cnt_reg == CNT_ZERO && !buf_reg)
    else $error("enable did not restart count and buffer");
  AST_ADDR_FIX: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    ch.wr_addr |=> addr_reg == $past(ch.wdata))
    else $error("corrected address not taken");
endmodule // dca_channel

// ---- hdl/dca_arbiter.sv ----
// Eight-channel fixed-priority request arbiter with register port
// Timing in brief
// Request pulse held at the next edge, if its channel is enabled.
// Idle arbiter grants one edge after the request is held.
// One idle cycle between transfers, so late arrivals join the choice.
// Address captured at grant; a correction moves later transfers only.
// Completion outside a transfer is ignored.
// Register port never stalls; read data stands for one cycle.
`timescale 1ns/1ps
module dca_arbiter
  import dca_pkg::*;
(
  input  wire logic           mclk_i,           // System clock, 40 MHz
  input  wire logic           rst_b_i,          // Synchronous reset, low
  input  wire logic [RAW-1:0] reg_addr_i,       // Register address
  input  wire logic [DW-1:0]  reg_wdata_i,      // Register write data
  input  wire logic           reg_wr_i,         // Write strobe
  input  wire logic           reg_rd_i,         // Read strobe
  output logic      [DW-1:0]  reg_rdata_o,      // Read data, next cycle
  input  wire logic [NCH-1:0] periph_req_i,     // Peripheral request pulses
  input  wire logic           xfer_done_i,      // Granted transfer finished
  output logic                xfer_req_o,       // Transfer in progress
  output logic      [NCH-1:0] xfer_gnt_o,       // One-hot channel grant
  output logic      [CHW-1:0] xfer_chan_o,      // Granted channel index
  output logic                xfer_dir_o,       // 1: memory to peripheral
  output logic      [DW-1:0]  xfer_addr_o       // Memory address of transfer
);
  dca_state_t     state_reg, state_next;
  logic [NCH-1:0] gnt_reg,   gnt_next;
  logic [CHW-1:0] chan_reg,  chan_next;
  logic           dir_reg,   dir_next;
  logic [DW-1:0]  addr_reg,  addr_next;
  logic [DW-1:0]  rdata_reg, rdata_next;
  logic [NCH-1:0] pend_vec;
  logic [NCH-1:0] ovr_vec;
  logic [NCH-1:0] dir_vec;
  logic [NCH-1:0] pick;
  logic [DW-1:0]  ctrl_rd [NCH];
  logic [DW-1:0]  cnt_rd  [NCH];
  logic [DW-1:0]  addr_rd [NCH];
  logic [CHW-1:0] sel_ch;
  logic [1:0]     sel_rg;
  logic           sel_glob;
  logic           done_ok;

  dca_ch_if ch_if [NCH] ();

  // Address decode fields
  assign sel_glob = reg_addr_i[AB_GLOBAL];
  assign sel_ch   = reg_addr_i[CH_MSB:CH_LSB];
  assign sel_rg   = reg_addr_i[RG_MSB:0];
  assign done_ok  = (state_reg == DCA_BUSY) & xfer_done_i;

  // One channel instance per request line
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      assign ch_if[gi].wr_ctrl    = reg_wr_i & ~sel_glob & (sel_ch == CHW'(gi))
                                  & (sel_rg == REG_CTRL);
      assign ch_if[gi].wr_addr    = reg_wr_i & ~sel_glob & (sel_ch == CHW'(gi))
                                  & (sel_rg == REG_ADDR);
      // Write-one-to-clear on the status word
      assign ch_if[gi].ovr_clr    = reg_wr_i & (reg_addr_i == ADDR_STATUS)
                                  & reg_wdata_i[gi];
      assign ch_if[gi].wdata      = reg_wdata_i;
      assign ch_if[gi].periph_req = periph_req_i[gi];
      assign ch_if[gi].grant      = gnt_reg[gi];
      assign ch_if[gi].done       = done_ok & gnt_reg[gi];
      assign pend_vec[gi]         = ch_if[gi].pending;
      assign ovr_vec[gi]          = ch_if[gi].overrun;
      assign dir_vec[gi]          = ch_if[gi].dir;
      assign addr_rd[gi]          = ch_if[gi].addr;
      assign ctrl_rd[gi]          = {ch_if[gi].en, ch_if[gi].dir, 4'h0, ch_if[gi].len};
      assign cnt_rd[gi]           = {5'h00, ch_if[gi].buf_sel, ch_if[gi].cnt};

      dca_channel u_ch (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .ch      (ch_if[gi])
      );
    end
  endgenerate

  // Lowest set bit of the pending set is the winner
  assign pick = pend_vec & (~pend_vec + VEC_ONE);

  // Arbiter next state; grant frozen while a transfer runs
  always_comb begin
    state_next = state_reg;
    gnt_next   = gnt_reg;
    chan_next  = chan_reg;
    dir_next   = dir_reg;
    addr_next  = addr_reg;
    unique case (state_reg)
      DCA_IDLE: begin
        if (pend_vec != VEC_ZERO) begin
          state_next = DCA_BUSY;
          gnt_next   = pick;
          for (int i = 0; i < NCH; i++) begin
            if (pick[i]) begin
              chan_next = i[CHW-1:0];
              dir_next  = dir_vec[i];
              addr_next = addr_rd[i];
            end
          end
        end
      end
      DCA_BUSY: begin
        // Peripheral data is read by the bus at transfer time, never latched here
        if (xfer_done_i) begin
          state_next = DCA_IDLE;
          gnt_next   = VEC_ZERO;
        end
      end
    endcase
  end

  // Arbiter registers
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      state_reg <= DCA_IDLE;
      gnt_reg   <= VEC_ZERO;
      chan_reg  <= CH_ZERO;
      dir_reg   <= 1'b0;
      addr_reg  <= DATA_ZERO;
    end else begin
      state_reg <= state_next;
      gnt_reg   <= gnt_next;
      chan_reg  <= chan_next;
      dir_reg   <= dir_next;
      addr_reg  <= addr_next;
    end
  end

  // Read mux; data only in the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_next = DATA_ZERO;
    if (reg_rd_i) begin
      if (reg_addr_i == ADDR_STATUS) begin
        rdata_next = {pend_vec, ovr_vec};
      end else if (reg_addr_i == ADDR_STATE) begin
        rdata_next = DATA_ZERO;
        rdata_next[STATE_BUSY_BIT] = (state_reg == DCA_BUSY);
        rdata_next[CHW-1:0]        = chan_reg;
      end else if (!sel_glob) begin
        unique case (sel_rg)
          REG_CTRL: rdata_next = ctrl_rd[sel_ch];
          REG_ADDR: rdata_next = addr_rd[sel_ch];
          REG_CNT:  rdata_next = cnt_rd[sel_ch];
          default:  rdata_next = DATA_ZERO;
        endcase
      end
    end
  end

  // Read data register
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rdata_reg <= DATA_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Outputs
  assign reg_rdata_o = rdata_reg;
  assign xfer_req_o  = (state_reg == DCA_BUSY);
  assign xfer_gnt_o  = gnt_reg;
  assign xfer_chan_o = chan_reg;
  assign xfer_dir_o  = dir_reg;
  assign xfer_addr_o = addr_reg;

  // Checks on arbitration
  AST_ONE_GRANT: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $onehot0(gnt_reg) && ((state_reg == DCA_BUSY) == (gnt_reg != VEC_ZERO)))
    else $error("grant not one-hot or out of step with state");
  AST_GRANT_HELD: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    state_reg == DCA_BUSY && !xfer_done_i |=> $stable(gnt_reg) && $stable(xfer_addr_o))
    else $error("grant moved before completion");
  AST_IMMEDIATE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    state_reg == DCA_IDLE && pend_vec != VEC_ZERO |=> state_reg == DCA_BUSY)
    else $error("pending request not granted next cycle");
  AST_PRIORITY: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(xfer_req_o) |-> ((gnt_reg & $past(pend_vec)) != VEC_ZERO)
      && ((((gnt_reg - VEC_ONE) & $past(pend_vec))) == VEC_ZERO))
    else $error("grant not given to highest-priority pending channel");
  AST_GRANT_PENDING: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    state_reg == DCA_BUSY |-> (gnt_reg & pend_vec) == gnt_reg)
    else $error("granted channel lost its request before completion");
  AST_DONE_IDLE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    done_ok |=> state_reg == DCA_IDLE ##1 ($past(pend_vec) == VEC_ZERO || xfer_req_o))
    else $error("no rearbitration after completion");
  AST_RESET: assert property (@(posedge mclk_i)
    !rst_b_i |=> gnt_reg == VEC_ZERO && pend_vec == VEC_ZERO && !xfer_req_o)
    else $error("grant or request left after reset");

  // Grant vector and channel index agree while a transfer is in progress
  AST_GNT_INDEX: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    xfer_req_o |-> gnt_reg == (VEC_ONE << chan_reg))
    else $error("grant vector and channel index disagree");

  // Index and direction frozen until the completion
  AST_CHAN_HELD: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    state_reg == DCA_BUSY && !xfer_done_i |=> $stable(chan_reg) && $stable(xfer_dir_o))
    else $error("channel or direction moved during transfer");

  // A grant needs a held request behind it
  AST_GNT_CAUSE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(xfer_req_o) |-> $past(pend_vec) != VEC_ZERO)
    else $error("grant raised with nothing pending");

  // Idle cycle after a transfer decides on what was held then
  AST_REARB: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $fell(xfer_req_o) |=> xfer_req_o == ($past(pend_vec) != VEC_ZERO))
    else $error("rearbitration did not follow the held set");

  // Completion outside a transfer must not clear a held request
  AST_STRAY_DONE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    state_reg == DCA_IDLE && xfer_done_i && !reg_wr_i
      |=> (pend_vec & $past(pend_vec)) == $past(pend_vec))
    else $error("stray completion cleared a request");

  // Read data stands one cycle after its strobe, zero otherwise
  AST_RD_IDLE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !$past(reg_rd_i) |-> reg_rdata_o == DATA_ZERO)
    else $error("read data outside its cycle");
  AST_STATUS_RD: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $past(reg_rd_i && reg_addr_i == ADDR_STATUS)
      |-> reg_rdata_o == $past({pend_vec, ovr_vec}))
    else $error("status read disagrees with held and overrun sets");
  AST_STATE_RD: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $past(reg_rd_i && reg_addr_i == ADDR_STATE)
      |-> reg_rdata_o[STATE_BUSY_BIT] == $past(xfer_req_o)
      && reg_rdata_o[CHW-1:0] == $past(xfer_chan_o))
    else $error("state read disagrees with the grant");

  // Per-channel checks at the arbiter boundary
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_chk
      // Enabled channel holds every request pulse
      AST_LATCH: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        periph_req_i[gi] && ch_if[gi].en && !reg_wr_i |=> pend_vec[gi])
        else $error("request pulse not held");

      // Waiting requests survive other channels' transfers
      AST_WAIT_HELD: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        pend_vec[gi] && !gnt_reg[gi] && !reg_wr_i |=> pend_vec[gi])
        else $error("waiting request lost");

      // Completion drops the request; a force then is ignored
      AST_DONE_DROP: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        done_ok && gnt_reg[gi] && !periph_req_i[gi] |=> !pend_vec[gi])
        else $error("request kept after completion");

      // Force on an idle, enabled channel is a request
      AST_FORCE_TAKE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        ch_if[gi].wr_ctrl && reg_wdata_i[CTRL_FORCE_BIT] && reg_wdata_i[CTRL_EN_BIT]
          && !gnt_reg[gi] |=> pend_vec[gi])
        else $error("forced request not held");

      // Disabling drops the held request
      AST_DIS_DROP: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        ch_if[gi].wr_ctrl && !reg_wdata_i[CTRL_EN_BIT] |=> !pend_vec[gi] && !ch_if[gi].en)
        else $error("disabled channel still holds a request");

      // Duplicate on a held inbound request marks overrun
      AST_OVR_SET: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        periph_req_i[gi] && pend_vec[gi] && !ch_if[gi].dir && !(done_ok && gnt_reg[gi])
          |=> ovr_vec[gi])
        else $error("inbound duplicate not flagged");

      // Outbound channels never raise overrun
      AST_OVR_M2P: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        ch_if[gi].dir && !ovr_vec[gi] |=> !ovr_vec[gi])
        else $error("outbound channel flagged overrun");

      // Clear with no new duplicate empties the flag
      AST_OVR_CLR: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        ch_if[gi].ovr_clr && !periph_req_i[gi] |=> !ovr_vec[gi])
        else $error("overrun flag not cleared");

      // Each completion steps the address unless software rewrites it
      AST_ADDR_NEXT: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        done_ok && gnt_reg[gi] && !ch_if[gi].wr_addr
          |=> addr_rd[gi] == $past(addr_rd[gi]) + ADDR_STEP)
        else $error("address did not step after completion");
    end
  endgenerate
endmodule // dca_arbiter

// ---- tb/dca_periph_model.sv ----
// Far-side peripheral request sources for the channel arbiter
`timescale 1ns/1ps
module dca_periph_model (
  input  wire logic       mclk_i,        // System clock
  input  wire logic       rst_b_i,       // Synchronous reset, low
  input  wire logic [7:0] event_i,       // Data arrived or transmitter ready
  output logic      [7:0] periph_req_o   // One-cycle request pulses
);
  // Pulse one clock after the event, with no start-up handshake needed
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      periph_req_o <= 8'h00;
    end else begin
      periph_req_o <= event_i;
    end
  end
endmodule // dca_periph_model

// ---- tb/dma_channel_arbiter_overrun_tb_top.sv ----
// Self-checking bench for the eight-channel request arbiter
`timescale 1ns/1ps
module dma_channel_arbiter_overrun_tb_top;
  import dca_pkg::*;
  typedef struct {logic [NCH-1:0] mask; logic [CHW-1:0] first;} dca_row_t;
  logic           mclk_i    = 1'b0;
  logic           rst_b_i   = 1'b0;
  logic [RAW-1:0] reg_addr  = 6'h00;
  logic [DW-1:0]  reg_wdata = 16'h0000;
  logic           reg_wr    = 1'b0;
  logic           reg_rd    = 1'b0;
  logic [NCH-1:0] ev        = 8'h00;
  logic           done      = 1'b0;
  logic [NCH-1:0] dir_map   = 8'hF7;     // Only channel 3 moves data into memory
  logic [DW-1:0]  rdata;
  logic [NCH-1:0] preq;
  logic [NCH-1:0] gnt;
  logic           xreq;
  logic           xdir;
  logic [CHW-1:0] xch;
  logic [DW-1:0]  xaddr;
  logic [DW-1:0]  exp_addr [NCH];
  int             n_errors  = 0;
  int             cmp_count = 0;
  dca_row_t rows [5] = '{'{8'h01, 3'h0}, '{8'h80, 3'h7}, '{8'hA4, 3'h2},
                         '{8'hFF, 3'h0}, '{8'h48, 3'h3}};

  // 40 MHz system clock
  always #12.5 mclk_i = ~mclk_i;

  dca_arbiter dca_arbiter_i (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .periph_req_i(preq),
    .xfer_done_i(done), .xfer_req_o(xreq), .xfer_gnt_o(gnt), .xfer_chan_o(xch),
    .xfer_dir_o(xdir), .xfer_addr_o(xaddr));
  dca_periph_model dca_periph_model_i (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .event_i(ev), .periph_req_o(preq));

  // Verdict and end of run
  task automatic test_done();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [RAW-1:0] ra(input int ch, input logic [1:0] r);
    return {1'b0, 3'(ch), r};
  endfunction

  function automatic logic [CHW-1:0] low(input logic [NCH-1:0] v);
    low = CH_ZERO;
    for (int i = NCH - 1; i >= 0; i--) if (v[i]) low = 3'(i);
  endfunction

  // Register port: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [RAW-1:0] a, input logic [DW-1:0] d);
    @(posedge mclk_i);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk_i);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [RAW-1:0] a, input logic [DW-1:0] exp);
    @(posedge mclk_i);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk_i);
    reg_rd   <= 1'b0;
    @(negedge mclk_i);
    chk(rdata, exp);
  endtask

  task automatic fire(input logic [NCH-1:0] m);
    @(posedge mclk_i);
    ev <= m;
    @(posedge mclk_i);
    ev <= 8'h00;
  endtask

  task automatic finish();
    @(posedge mclk_i);
    done <= 1'b1;
    @(posedge mclk_i);
    done <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(negedge mclk_i);
      chk({15'h0000, xreq}, 16'h0000);
    end
  endtask

  // Bounded wait for a grant; n_exp of zero skips the latency check
  task automatic wait_gnt(input logic [CHW-1:0] ch, input int n_exp);
    int n;
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
      if (n > 40) begin
        n_errors++;
        test_done();
      end
    end while (xreq !== 1'b1);
    if (n_exp > 0) chk(16'(n), 16'(n_exp));
    chk({8'h00, gnt}, {8'h00, VEC_ONE << ch});
    chk({13'h0000, xch}, {13'h0000, ch});
    chk({15'h0000, xdir}, {15'h0000, dir_map[ch]});
    chk(xaddr, exp_addr[ch]);
    exp_addr[ch] = exp_addr[ch] + ADDR_STEP;
  endtask

  initial begin
    logic [NCH-1:0] left;
    logic [CHW-1:0] ch;
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(negedge mclk_i);
    chk({15'h0000, xreq}, 16'h0000);
    chk({8'h00, gnt}, 16'h0000);
    rd(ADDR_STATUS, 16'h0000);
    rd(ra(4, REG_CTRL), 16'h0000);
    // Enable every channel with a distinct buffer address
    for (int i = 0; i < NCH; i++) begin
      exp_addr[i] = 16'h0100 + 16'(i * 16);
      wr(ra(i, REG_ADDR), exp_addr[i]);
      wr(ra(i, REG_CTRL), {1'b1, dir_map[i], 4'h0, 10'h3FF});
    end
    rd(6'h3F, 16'h0000);
    rd(ra(0, 2'h3), 16'h0000);
    // Table: simultaneous requests drain lowest index first
    foreach (rows[r]) begin
      fire(rows[r].mask);
      left = rows[r].mask;
      while (left != 8'h00) begin
        ch = (left == rows[r].mask) ? rows[r].first : low(left);
        wait_gnt(ch, (left == rows[r].mask) ? 3 : 0);
        finish();
        left[ch] = 1'b0;
      end
      idle(3);
    end
    // Duplicates while the first request is still held
    fire(8'h01);
    wait_gnt(3'h0, 3);
    // Overrunning sources raise a second request on held channels
    fire(8'h18);
    fire(8'h18);
    rd(ADDR_STATUS, 16'h1908);
    finish();
    wait_gnt(3'h3, 0);
    finish();
    wait_gnt(3'h4, 0);
    finish();
    idle(6);
    finish();
    rd(ADDR_STATUS, 16'h0008);
    wr(ADDR_STATUS, 16'h0008);
    rd(ADDR_STATUS, 16'h0000);
    // Software moves the faulted channel's address
    exp_addr[3] = 16'h0200;
    wr(ra(3, REG_ADDR), 16'h0200);
    fire(8'h08);
    wait_gnt(3'h3, 3);
    finish();
    rd(ra(3, REG_ADDR), 16'h0201);
    // Arrivals during a transfer wait, then lowest index wins
    fire(8'h20);
    wait_gnt(3'h5, 3);
    fire(8'h40);
    fire(8'h02);
    @(negedge mclk_i);
    chk({8'h00, gnt}, 16'h0020);
    rd(ADDR_STATE, 16'h8005);
    finish();
    wait_gnt(3'h1, 0);
    finish();
    wait_gnt(3'h6, 0);
    finish();
    // Disable and re-enable restarts the count
    rd(ra(1, REG_CNT), 16'h0002);
    wr(ra(1, REG_CTRL), 16'h43FF);
    wr(ra(1, REG_CTRL), 16'hC3FF);
    rd(ra(1, REG_CNT), 16'h0000);
    // Forced transfers from idle; a force in mid-transfer is ignored
    wr(ra(2, REG_CTRL), 16'hE3FF);
    wait_gnt(3'h2, 0);
    wr(ra(2, REG_CTRL), 16'hE3FF);
    // Force again in the completion cycle itself
    @(posedge mclk_i);
    reg_addr  <= ra(2, REG_CTRL);
    reg_wdata <= 16'hE3FF;
    reg_wr    <= 1'b1;
    done      <= 1'b1;
    @(posedge mclk_i);
    reg_wr    <= 1'b0;
    done      <= 1'b0;
    idle(4);
    wr(ra(2, REG_CTRL), 16'hE3FF);
    wait_gnt(3'h2, 0);
    finish();
    rd(ra(2, REG_CTRL), 16'hC3FF);
    test_done();
  end
endmodule // dma_channel_arbiter_overrun_tb_top
